// >>> src/fflib_pkg.sv
// Purpose: Shared types and constants for the storage element library
// Assumes: One clock domain, element inputs are sampled by the library
// Notes:   Element pins travel as packed structs, except the gated latch's single gate pin

package fflib_pkg;

    // =========================================================
    // Synchroniser and reset values
    // =========================================================
    localparam int          SYNC_STAGES = 3;
    localparam logic        RST_STATE   = 1'b0;
    // Synchronisers start at idle pin levels, so no active-low direct
    // input looks active in the cycles right after reset
    localparam logic [27:0] SYNC_RST    = 28'h3006804;
    // Seed for the unpredictable release choice of the set-reset latch
    localparam logic [7:0]  LFSR_SEED   = 8'hA5;
    localparam logic [7:0]  LFSR_TAPS   = 8'hB8;

    // =========================================================
    // Element pin groups
    // =========================================================
    typedef struct packed {
        logic set;
        logic reset;
    } fflib_sr_s;

    typedef struct packed {
        logic j;
        logic k;
        logic clk;
    } fflib_jk_s;

    typedef struct packed {
        logic set_n;
        logic reset_n;
        logic j;
        logic k_n;
        logic clk;
    } fflib_jkd_s;

    typedef struct packed {
        logic d;
        logic clk;
        logic clear;
        logic set;
        logic direct_clear;
    } fflib_d_s;

    typedef struct packed {
        logic toggle;
        logic reset;
    } fflib_t_s;

    typedef struct packed {
        logic true_output;
        logic complement_output;
    } fflib_out_s;

endpackage : fflib_pkg

// >>> src/fflib_top.sv
// What this block does
// R1 - Set-reset latch: set alone drives true high, reset alone true low.
// R2 - Set and reset both high drive both outputs high.
// R3 - Release from both high to both low, or power-up, settles randomly; reset loads zero into the latch.
// R4 - Driving logic should avoid asserting set and reset together.
// R5 - Both inputs low keep the present outputs.
// R6 - Inverted-input latch acts on zero levels, else like the plain latch; release from both low holds true high.
// R7 - Gated latch acts on set and reset only while its clock is high.
// R8 - JK at clock edge: J sets, K resets, neither holds.
// R9 - JK with both J and K high toggles at each edge.
// R10 - K-inverted JK reads K with inverted polarity, otherwise identical.
// R11 - Direct active-low set/reset act at once; both force both outputs high.
// R12 - Directs idle: J0/nK0 clear, J1/nK1 set, J1/nK0 toggle, J0/nK1 hold.
// R13 - Master/slave JK captures on rising edge, shows on next falling edge.
// R14 - D latch follows data while clock high, holds while low.
// R15 - Edge D flip-flop stores data only on a rising clock edge.
// R16 - D with clear forces zero while clear is high, else edge stores.
// R17 - D set/clear: clear low clears, set high sets, both force both high.
// R18 - Set/clear idle: store data on rising edge, otherwise hold.
// R19 - Toggle element inverts outputs on each rising toggle edge.
// R20 - Toggle element starts arbitrary; complement is always inverse of true.
// R21 - Toggle with reset forces true low while reset high, else toggles.
// R22 - Edges found by comparing level with last sample; directs act directly.
//
// Purpose: Behavioural library of single-bit storage elements on one clock
// Assumes: All element inputs come from pins, so each is synchronised
// Notes:   Outputs lag inputs by the synchroniser depth plus two cycles

`timescale 1ns/1ps

module fflib_top
(
    // Clock and reset
    input  wire logic                clock_in,
    input  wire logic                nrst_in,
    // Set-reset latches
    input  wire fflib_pkg::fflib_sr_s  sr_in,
    input  wire fflib_pkg::fflib_sr_s  srn_in,
    input  wire fflib_pkg::fflib_sr_s  srg_in,
    input  wire logic                  srg_gate_in,
    // JK elements
    input  wire fflib_pkg::fflib_jk_s  jk_in,
    input  wire fflib_pkg::fflib_jk_s  jkn_in,
    input  wire fflib_pkg::fflib_jkd_s jkd_in,
    input  wire fflib_pkg::fflib_jk_s  jkms_in,
    // D and toggle elements
    input  wire fflib_pkg::fflib_d_s   d_in,
    input  wire fflib_pkg::fflib_t_s   t_in,
    // Element outputs
    output fflib_pkg::fflib_out_s      sr_out,
    output fflib_pkg::fflib_out_s      srn_out,
    output fflib_pkg::fflib_out_s      srg_out,
    output fflib_pkg::fflib_out_s      jk_out,
    output fflib_pkg::fflib_out_s      jkn_out,
    output fflib_pkg::fflib_out_s      jkd_out,
    output fflib_pkg::fflib_out_s      jkms_out,
    output fflib_pkg::fflib_out_s      dlat_out,
    output fflib_pkg::fflib_out_s      dedge_out,
    output fflib_pkg::fflib_out_s      dclr_out,
    output fflib_pkg::fflib_out_s      dsc_out,
    output fflib_pkg::fflib_out_s      tff_out,
    output fflib_pkg::fflib_out_s      tffr_out
);

    // =========================================================
    // Input synchronisers
    // =========================================================
    localparam int NIN = 28;
    logic [NIN-1:0] raw;
    logic [NIN-1:0] s1_ff, s2_ff, s3_ff, stab_ff;
    logic [NIN-1:0] nxt_stab;

    assign raw = {sr_in, srn_in, srg_in, srg_gate_in, jk_in, jkn_in,
                  jkd_in, jkms_in, d_in, t_in};

    // A change is accepted only once stages two and three agree
    genvar gi;
    generate
        for (gi = 0; gi < NIN; gi++)
        begin : g_sync
            always_comb
            begin
                nxt_stab[gi] = (s2_ff[gi] == s3_ff[gi]) ? s3_ff[gi]
                                                         : stab_ff[gi];
            end
        end
    endgenerate

    always_ff @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            s1_ff   <= fflib_pkg::SYNC_RST;
            s2_ff   <= fflib_pkg::SYNC_RST;
            s3_ff   <= fflib_pkg::SYNC_RST;
            stab_ff <= fflib_pkg::SYNC_RST;
        end
        else
        begin
            s1_ff   <= raw;
            s2_ff   <= s1_ff;
            s3_ff   <= s2_ff;
            stab_ff <= nxt_stab;
        end
    end

    fflib_pkg::fflib_sr_s  sr, srn, srg;
    fflib_pkg::fflib_jk_s  jk, jkn, jkms;
    fflib_pkg::fflib_jkd_s jkd;
    fflib_pkg::fflib_d_s   dd;
    fflib_pkg::fflib_t_s   tt;
    logic                  gate;
    assign {sr, srn, srg, gate, jk, jkn, jkd, jkms, dd, tt} = stab_ff;

    // =========================================================
    // Edge history and random source
    // =========================================================
    logic [5:0] prev_ff, nxt_prev;
    logic [7:0] lfsr_ff, nxt_lfsr;
    logic       both_ff, nxt_both;
    logic       rnd;

    always_comb
    begin
        nxt_prev = {jk.clk, jkn.clk, jkd.clk, jkms.clk, dd.clk, tt.toggle};
        nxt_lfsr = lfsr_ff[0] ? ((lfsr_ff >> 1) ^ fflib_pkg::LFSR_TAPS)
                              : (lfsr_ff >> 1);
        nxt_both = sr.set & sr.reset;
    end
    assign rnd = lfsr_ff[0];

    wire rise_jk   = jk.clk    & ~prev_ff[5];                           // R22
    wire rise_jkn  = jkn.clk   & ~prev_ff[4];                           // R22
    wire rise_jkd  = jkd.clk   & ~prev_ff[3];                           // R22
    wire rise_ms   = jkms.clk  & ~prev_ff[2];                           // R22
    wire fall_ms   = ~jkms.clk &  prev_ff[2];                           // R22
    wire rise_d    = dd.clk    & ~prev_ff[1];                           // R22
    wire rise_t    = tt.toggle & ~prev_ff[0];                           // R22

    // =========================================================
    // Element state
    // =========================================================
    logic sr_q_ff, srn_q_ff, srg_q_ff, jk_q_ff, jkn_q_ff, jkd_q_ff;
    logic msm_ff, mss_ff, dlat_ff, dedge_ff, dclr_ff, dsc_ff, t_ff, tr_ff;
    logic nxt_sr, nxt_srn, nxt_srg, nxt_jk, nxt_jkn, nxt_jkd;
    logic nxt_msm, nxt_mss, nxt_dlat, nxt_dedge, nxt_dclr, nxt_dsc;
    logic nxt_t, nxt_tr;

    // Plain JK next state; both high toggles
    function automatic logic jk_next(input logic q, input logic j,
                                     input logic k);
        jk_next = (j & ~q) | (~k & q);                                  // R8 R9
    endfunction : jk_next

    always_comb
    begin
        // Set wins so both-high reads 1 on true; release picks at random
        nxt_sr = sr_q_ff;
        if (sr.set)
            nxt_sr = 1'b1;                                              // R1 R2
        else if (sr.reset)
            nxt_sr = 1'b0;                                              // R1
        else if (both_ff)
            nxt_sr = rnd;                                               // R3
        nxt_srn = srn_q_ff;
        if (~srn.set)
            nxt_srn = 1'b1;                                             // R6
        else if (~srn.reset)
            nxt_srn = 1'b0;                                             // R6
        nxt_srg = srg_q_ff;
        if (gate & srg.set)
            nxt_srg = 1'b1;                                             // R7
        else if (gate & srg.reset)
            nxt_srg = 1'b0;                                             // R7
        nxt_jk  = rise_jk  ? jk_next(jk_q_ff, jk.j, jk.k) : jk_q_ff;
        nxt_jkn = rise_jkn ? jk_next(jkn_q_ff, jkn.j, ~jkn.k)           // R10
                           : jkn_q_ff;
        nxt_jkd = rise_jkd ? jk_next(jkd_q_ff, jkd.j, ~jkd.k_n)         // R12
                           : jkd_q_ff;
        if (~jkd.set_n)
            nxt_jkd = 1'b1;                                             // R11
        else if (~jkd.reset_n)
            nxt_jkd = 1'b0;                                             // R11
        nxt_msm = rise_ms ? jk_next(mss_ff, jkms.j, jkms.k) : msm_ff;   // R13
        nxt_mss = fall_ms ? msm_ff : mss_ff;                            // R13
        nxt_dlat  = dd.clk ? dd.d : dlat_ff;                            // R14
        nxt_dedge = rise_d ? dd.d : dedge_ff;                           // R15
        nxt_dclr  = dd.clear ? 1'b0 : (rise_d ? dd.d : dclr_ff);        // R16
        nxt_dsc = rise_d ? dd.d : dsc_ff;                               // R18
        if (dd.set)
            nxt_dsc = 1'b1;                                             // R17
        else if (~dd.direct_clear)
            nxt_dsc = 1'b0;                                             // R17
        nxt_t  = rise_t ? ~t_ff : t_ff;                                 // R19
        nxt_tr = tt.reset ? 1'b0 : (rise_t ? ~tr_ff : tr_ff);           // R21
    end

    // Power-up state of the toggle is arbitrary; zero is one such state
    always_ff @(posedge clock_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            prev_ff  <= '0;
            lfsr_ff  <= fflib_pkg::LFSR_SEED;
            both_ff  <= 1'b0;
            sr_q_ff  <= fflib_pkg::RST_STATE;
            srn_q_ff <= fflib_pkg::RST_STATE;
            srg_q_ff <= fflib_pkg::RST_STATE;
            jk_q_ff  <= fflib_pkg::RST_STATE;
            jkn_q_ff <= fflib_pkg::RST_STATE;
            jkd_q_ff <= fflib_pkg::RST_STATE;
            msm_ff   <= fflib_pkg::RST_STATE;
            mss_ff   <= fflib_pkg::RST_STATE;
            dlat_ff  <= fflib_pkg::RST_STATE;
            dedge_ff <= fflib_pkg::RST_STATE;
            dclr_ff  <= fflib_pkg::RST_STATE;
            dsc_ff   <= fflib_pkg::RST_STATE;
            t_ff     <= fflib_pkg::RST_STATE;                           // R20
            tr_ff    <= fflib_pkg::RST_STATE;
        end
        else
        begin
            prev_ff  <= nxt_prev;
            lfsr_ff  <= nxt_lfsr;
            both_ff  <= nxt_both;
            sr_q_ff  <= nxt_sr;
            srn_q_ff <= nxt_srn;
            srg_q_ff <= nxt_srg;
            jk_q_ff  <= nxt_jk;
            jkn_q_ff <= nxt_jkn;
            jkd_q_ff <= nxt_jkd;
            msm_ff   <= nxt_msm;
            mss_ff   <= nxt_mss;
            dlat_ff  <= nxt_dlat;
            dedge_ff <= nxt_dedge;
            dclr_ff  <= nxt_dclr;
            dsc_ff   <= nxt_dsc;
            t_ff     <= nxt_t;
            tr_ff    <= nxt_tr;
        end
    end

    // =========================================================
    // Outputs
    // =========================================================
    // Both-active cases drive both outputs high; the driver should avoid them
    wire sr_both  = sr.set & sr.reset;                                  // R2 R4
    wire srn_both = ~srn.set & ~srn.reset;                              // R6
    wire srg_both = gate & srg.set & srg.reset;                         // R7
    wire jkd_both = ~jkd.set_n & ~jkd.reset_n;                          // R11
    wire dsc_both = dd.set & ~dd.direct_clear;                          // R17

    assign sr_out    = '{sr_q_ff,  ~sr_q_ff  | sr_both};                // R5
    assign srn_out   = '{srn_q_ff, ~srn_q_ff | srn_both};
    assign srg_out   = '{srg_q_ff, ~srg_q_ff | srg_both};
    assign jk_out    = '{jk_q_ff,  ~jk_q_ff};
    assign jkn_out   = '{jkn_q_ff, ~jkn_q_ff};
    assign jkd_out   = '{jkd_q_ff, ~jkd_q_ff | jkd_both};
    assign jkms_out  = '{mss_ff,   ~mss_ff};
    assign dlat_out  = '{dlat_ff,  ~dlat_ff};
    assign dedge_out = '{dedge_ff, ~dedge_ff};
    assign dclr_out  = '{dclr_ff,  ~dclr_ff};
    assign dsc_out   = '{dsc_ff,   ~dsc_ff | dsc_both};
    assign tff_out   = '{t_ff,     ~t_ff};                              // R20
    assign tffr_out  = '{tr_ff,    ~tr_ff};

    // =========================================================
    // Checks
    // =========================================================
    property p_sr_set;
        @(posedge clock_in) disable iff (!nrst_in)
        (sr.set & ~sr.reset) |=> sr_out.true_output;
    endproperty
    a_sr_set: assert property (p_sr_set)                                // R1
        else $error("latch did not set");

    property p_sr_both;
        @(posedge clock_in) disable iff (!nrst_in)
        sr_both |=> sr_out.true_output;
    endproperty
    a_sr_both: assert property (p_sr_both)                              // R2
        else $error("both-high latch true output not high");

    property p_sr_hold;
        @(posedge clock_in) disable iff (!nrst_in)
        (~sr.set & ~sr.reset & ~both_ff) |=> $stable(sr_q_ff);
    endproperty
    a_sr_hold: assert property (p_sr_hold)                              // R5
        else $error("idle latch changed");

    property p_gate_hold;
        @(posedge clock_in) disable iff (!nrst_in)
        ~gate |=> $stable(srg_q_ff);
    endproperty
    a_gate_hold: assert property (p_gate_hold)                          // R7
        else $error("gated latch moved while gate low");

    property p_jk_tog;
        @(posedge clock_in) disable iff (!nrst_in)
        (rise_jk & jk.j & jk.k) |=> (jk_q_ff != $past(jk_q_ff));
    endproperty
    a_jk_tog: assert property (p_jk_tog)                                // R9
        else $error("jk did not toggle");

    property p_ms_slave;
        @(posedge clock_in) disable iff (!nrst_in)
        ~fall_ms |=> $stable(mss_ff);
    endproperty
    a_ms_slave: assert property (p_ms_slave)                            // R13
        else $error("master slave output moved off falling edge");

    property p_dedge;
        @(posedge clock_in) disable iff (!nrst_in)
        rise_d |=> (dedge_ff == $past(dd.d));
    endproperty
    a_dedge: assert property (p_dedge)                                  // R15
        else $error("edge d did not capture");

    property p_dclr;
        @(posedge clock_in) disable iff (!nrst_in)
        dd.clear |=> ~dclr_ff;
    endproperty
    a_dclr: assert property (p_dclr)                                    // R16
        else $error("clear did not zero");

    property p_tr;
        @(posedge clock_in) disable iff (!nrst_in)
        tt.reset |=> ~tffr_out.true_output;
    endproperty
    a_tr: assert property (p_tr)                                        // R21
        else $error("toggle reset did not zero");

endmodule : fflib_top

// >>> test/fflib_logic_drv.sv
// Purpose: Model of the surrounding logic that drives the library's pins
// Assumes: Pins change 1 ns after a rising clock edge
// Notes:   Each level is held HOLD cycles, longer than the input latency

`timescale 1ns/1ps

module fflib_logic_drv
#(
    parameter int HOLD = 8
)
(
    // Clock
    input  wire logic                  clock_in,
    // Driven pin groups
    output fflib_pkg::fflib_sr_s       sr_out,
    output fflib_pkg::fflib_sr_s       srn_out,
    output fflib_pkg::fflib_sr_s       srg_out,
    output logic                       srg_gate_out,
    output fflib_pkg::fflib_jk_s       jk_out,
    output fflib_pkg::fflib_jk_s       jkn_out,
    output fflib_pkg::fflib_jkd_s      jkd_out,
    output fflib_pkg::fflib_jk_s       jkms_out,
    output fflib_pkg::fflib_d_s        d_out,
    output fflib_pkg::fflib_t_s        t_out
);

    // =========================================================
    // Idle levels: every direct input inactive
    // =========================================================
    initial
    begin
        sr_out       = 2'h0;
        srn_out      = 2'h3;
        srg_out      = 2'h0;
        srg_gate_out = 1'h0;
        jk_out       = 3'h0;
        jkn_out      = 3'h0;
        jkd_out      = 5'h1A;
        jkms_out     = 3'h0;
        d_out        = 5'h01;
        t_out        = 2'h0;
    end

    // =========================================================
    // Hold a level long enough for every change to be seen
    // =========================================================
    // Pulses shorter than two cycles never make stages two and three agree and are lost
    task automatic settle();
        repeat (HOLD) @(posedge clock_in);
        #1;
    endtask : settle

endmodule : fflib_logic_drv

// >>> test/tb_top.sv
// Purpose: Self-checking bench for the storage element library
// Assumes: Outputs settle within the partner's hold time
// Notes:   o[] order: sr srn srg jk jkn jkd jkms dlat dedge dclr dsc tff tffr

`timescale 1ns/1ps

module tb_top;

    // =========================================================
    // Clock, reset, pins
    // =========================================================
    logic                    clock_in = 1'b0;
    logic                    nrst_in  = 1'b0;
    int                      miscompares = 0;
    int                      num_checks  = 0;
    wire fflib_pkg::fflib_sr_s  sr_w, srn_w, srg_w;
    wire logic                  gate_w;
    wire fflib_pkg::fflib_jk_s  jk_w, jkn_w, jkms_w;
    wire fflib_pkg::fflib_jkd_s jkd_w;
    wire fflib_pkg::fflib_d_s   d_w;
    wire fflib_pkg::fflib_t_s   t_w;
    fflib_pkg::fflib_out_s      o [13];

    always #20 clock_in = ~clock_in;

    fflib_logic_drv drv (.clock_in(clock_in), .sr_out(sr_w), .srn_out(srn_w),
        .srg_out(srg_w), .srg_gate_out(gate_w), .jk_out(jk_w),
        .jkn_out(jkn_w), .jkd_out(jkd_w), .jkms_out(jkms_w), .d_out(d_w),
        .t_out(t_w));

    fflib_top dut (.clock_in(clock_in), .nrst_in(nrst_in), .sr_in(sr_w),
        .srn_in(srn_w), .srg_in(srg_w), .srg_gate_in(gate_w), .jk_in(jk_w),
        .jkn_in(jkn_w), .jkd_in(jkd_w), .jkms_in(jkms_w), .d_in(d_w),
        .t_in(t_w), .sr_out(o[0]), .srn_out(o[1]), .srg_out(o[2]),
        .jk_out(o[3]), .jkn_out(o[4]), .jkd_out(o[5]), .jkms_out(o[6]),
        .dlat_out(o[7]), .dedge_out(o[8]), .dclr_out(o[9]), .dsc_out(o[10]),
        .tff_out(o[11]), .tffr_out(o[12]));

    // =========================================================
    // Checking and closing
    // =========================================================
    task automatic chk(input string nm, input fflib_pkg::fflib_out_s exp,
                       input fflib_pkg::fflib_out_s got);
        num_checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %b seen %b", nm, exp, got);
        end
    endtask : chk

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop

    // =========================================================
    // Scenarios
    // =========================================================
    task automatic t_latches();
        drv.sr_out = 2'h2; drv.srn_out = 2'h1; drv.settle();
        chk("sr set", 2'h2, o[0]);
        chk("srn set", 2'h2, o[1]);
        drv.sr_out = 2'h0; drv.srn_out = 2'h3; drv.settle();
        chk("sr hold", 2'h2, o[0]);
        drv.sr_out = 2'h1; drv.srn_out = 2'h2; drv.settle();
        chk("sr reset", 2'h1, o[0]);
        chk("srn reset", 2'h1, o[1]);
        // Both active on purpose, the driver normally avoids this
        drv.sr_out = 2'h3; drv.srn_out = 2'h0; drv.settle();
        chk("sr both", 2'h3, o[0]);
        chk("srn both", 2'h3, o[1]);
        drv.sr_out = 2'h0; drv.settle();
        chk("sr release", o[0].true_output ? 2'h2 : 2'h1, o[0]);
        drv.srg_out = 2'h2; drv.settle();
        chk("srg closed", 2'h1, o[2]);
        drv.srg_gate_out = 1'h1; drv.settle();
        chk("srg open", 2'h2, o[2]);
        drv.srg_gate_out = 1'h0; drv.srg_out = 2'h1; drv.settle();
        chk("srg hold", 2'h2, o[2]);
        drv.srg_gate_out = 1'h1; drv.settle();
        chk("srg reset", 2'h1, o[2]);
    endtask : t_latches

    // Same j/k to plain, K-inverted and master/slave elements
    task automatic jk_pulse(input logic j, input logic k, input logic q0,
                            input logic q1);
        drv.jk_out = {j, k, 1'b0};
        drv.jkn_out = {j, ~k, 1'b0};
        drv.jkms_out = {j, k, 1'b0};
        drv.settle();
        drv.jk_out.clk = 1'b1;
        drv.jkn_out.clk = 1'b1;
        drv.jkms_out.clk = 1'b1;
        drv.settle();
        chk("jk", {q1, ~q1}, o[3]);
        chk("jkn", {q1, ~q1}, o[4]);
        chk("jkms high", {q0, ~q0}, o[6]);
        drv.jkms_out.clk = 1'b0;
        drv.settle();
        chk("jkms fall", {q1, ~q1}, o[6]);
    endtask : jk_pulse

    task automatic jkd_edge(input logic j, input logic kn, input logic q);
        drv.jkd_out = {2'h3, j, kn, 1'b0};
        drv.settle();
        drv.jkd_out.clk = 1'b1;
        drv.settle();
        chk("jkd edge", {q, ~q}, o[5]);
    endtask : jkd_edge

    task automatic t_direct();
        drv.jkd_out.set_n = 1'b0; drv.settle();
        chk("jkd set", 2'h2, o[5]);
        drv.jkd_out = 5'h12; drv.settle();
        chk("jkd clear", 2'h1, o[5]);
        drv.jkd_out = 5'h02; drv.settle();
        chk("jkd both", 2'h3, o[5]);
        jkd_edge(1'b0, 1'b0, 1'b0);
        jkd_edge(1'b1, 1'b1, 1'b1);
        jkd_edge(1'b1, 1'b0, 1'b0);
        jkd_edge(1'b0, 1'b1, 1'b0);
        jkd_edge(1'b1, 1'b0, 1'b1);
        drv.d_out.direct_clear = 1'b0; drv.settle();
        chk("dsc clear", 2'h1, o[10]);
        drv.d_out.set = 1'b1; drv.settle();
        chk("dsc both", 2'h3, o[10]);
        drv.d_out.direct_clear = 1'b1; drv.settle();
        chk("dsc set", 2'h2, o[10]);
        drv.d_out = 5'h00; drv.settle();
        chk("dsc clear again", 2'h1, o[10]);
        drv.d_out = 5'h01; drv.settle();
    endtask : t_direct

    task automatic t_data();
        drv.d_out.d = 1'b1; drv.settle();
        chk("dlat closed", 2'h1, o[7]);
        chk("dedge idle", 2'h1, o[8]);
        drv.d_out.clk = 1'b1; drv.settle();
        chk("dlat open", 2'h2, o[7]);
        chk("dedge rise", 2'h2, o[8]);
        chk("dclr rise", 2'h2, o[9]);
        chk("dsc rise", 2'h2, o[10]);
        drv.d_out.d = 1'b0; drv.settle();
        chk("dlat follow", 2'h1, o[7]);
        chk("dedge level", 2'h2, o[8]);
        chk("dsc level", 2'h2, o[10]);
        drv.d_out.clear = 1'b1; drv.settle();
        chk("dclr clear", 2'h1, o[9]);
        drv.d_out.clk = 1'b0; drv.d_out.d = 1'b1; drv.settle();
        chk("dlat retain", 2'h1, o[7]);
        drv.d_out.clk = 1'b1; drv.settle();
        chk("dclr held", 2'h1, o[9]);
        drv.d_out = 5'h01; drv.settle();
    endtask : t_data

    task automatic t_toggle();
        logic q;
        q = 1'b0;
        for (int i = 0; i < 2; i++)
        begin
            drv.t_out = 2'h2; drv.settle();
            q = ~q;
            chk("tff rise", {q, ~q}, o[11]);
            chk("tffr rise", {q, ~q}, o[12]);
            drv.t_out = 2'h0; drv.settle();
            chk("tff hold", {q, ~q}, o[11]);
        end
        drv.t_out = 2'h3; drv.settle();
        chk("tff in reset", 2'h2, o[11]);
        chk("tffr in reset", 2'h1, o[12]);
        drv.t_out = 2'h0; drv.settle();
        drv.t_out = 2'h2; drv.settle();
        chk("tffr after", 2'h2, o[12]);
    endtask : t_toggle

    // =========================================================
    // Main sequence and watchdog
    // =========================================================
    initial
    begin
        repeat (2) @(posedge clock_in);
        #1 nrst_in = 1'b1;
        drv.settle();
        for (int i = 0; i < 13; i++)
            chk("reset state", 2'h1, o[i]);
        t_latches();
        jk_pulse(1'b1, 1'b0, 1'b0, 1'b1);
        jk_pulse(1'b0, 1'b0, 1'b1, 1'b1);
        jk_pulse(1'b0, 1'b1, 1'b1, 1'b0);
        jk_pulse(1'b1, 1'b1, 1'b0, 1'b1);
        jk_pulse(1'b1, 1'b1, 1'b1, 1'b0);
        t_direct();
        t_data();
        t_toggle();
        report_and_stop();
    end

    // Whole run needs under 2000 cycles
    initial
    begin
        repeat (20000) @(posedge clock_in);
        miscompares++;
        report_and_stop();
    end

endmodule : tb_top
